// ===== core/adc_dev_end.sv
// Converter end: serial port, sync and reset pins, conversion timing
`timescale 1ns/10ps
// Functional notes
// - Host keeps serial clock phases 0.8-10 master clocks.
// - 64 ready falls with clock low idles port.
// - Host waits 24 master clocks before data.
// - Input taken on rise, output shifts after fall.
// - Result MSB on output when ready falls.
// - Next result within one period after read.
// - Sync pin sampled only on master clock edges.
// - Host holds sync levels two master clocks.
// - Aligned continuous sync clock causes no resync.
// - FIR first result after sync 62.98046875 periods plus 466 (plus 468 after reset).
// - Reset sampled on clock, two low clocks needed.
// - Sync restarts filter and modulator.
// - Reset restores defaults and restarts conversion.
module adc_dev_end #(
  parameter int DATA_PERIOD = adc_link_pkg::DATA_PERIOD_DEF // mclk per word
) (
  input  wire logic                               link_clk,       // master
  input  wire logic                               rst,            // sync, high
  adc_link_if.dev                                 link,           // pins
  input  wire logic [adc_link_pkg::RESULT_BITS-1:0] sample_in,    // filter out
  output logic                                    sample_take,    // captured
  output logic                                    filter_restart, // restart
  output logic                                    fir_sel,        // FIR path
  output logic                                    csync_en        // cont sync
);
  import adc_link_pkg::*;

  localparam int          FIR_SETTLE  =
    DATA_PERIOD * FIR_SETTLE_NUM / FIR_SETTLE_DEN;
  localparam logic [31:0] PERIOD_LAST = 32'(DATA_PERIOD - 1);
  localparam logic [31:0] SYNC_WAIT   = 32'(FIR_SETTLE + SYNC_SETTLE_MCLK);
  localparam logic [31:0] RESET_WAIT  = 32'(FIR_SETTLE + RESET_SETTLE_MCLK);
  localparam logic [31:0] SINC_WAIT   = 32'(DATA_PERIOD);
  localparam logic [3:0]  PIN_IDLE    = 4'h8;

  typedef enum logic [1:0] {
    D_CMD   = 2'b00,
    D_WDATA = 2'b01,
    D_RDOUT = 2'b10
  } dev_state_t;

  function automatic logic [REG_BITS-1:0] cfg_default(input int idx);
    cfg_default = (idx == 0) ? CFG0_RST : CFG_OTHER_RST;
  endfunction

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic [3:0] pin_s3_r;

  always_ff @(posedge link_clk) begin
    if (rst) begin
      pin_s1_r <= PIN_IDLE;
      pin_s2_r <= PIN_IDLE;
      pin_s3_r <= PIN_IDLE;
    end else begin
      pin_s1_r <= {link.reset_n, link.sync, link.din, link.sclk};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  logic sclk_hi;
  logic sclk_rise;
  logic sclk_fall;
  logic din_s;
  logic sync_rise;
  logic rstn_lo;
  assign sclk_hi   = pin_s2_r[0];
  assign sclk_rise = pin_s2_r[0] & ~pin_s3_r[0];
  assign sclk_fall = ~pin_s2_r[0] & pin_s3_r[0];
  assign din_s     = pin_s2_r[1];
  assign sync_rise = pin_s2_r[2] & ~pin_s3_r[2];
  assign rstn_lo   = ~pin_s2_r[3];

  // ************************************************************
  // Serial port and conversion state
  // ************************************************************
  dev_state_t                st_r;
  dev_state_t                st_nxt;
  logic [7:0]                in_r;
  logic [7:0]                in_nxt;
  logic [5:0]                bit_r;
  logic [5:0]                bit_nxt;
  logic [5:0]                len_r;
  logic [5:0]                len_nxt;
  logic [RESULT_BITS-1:0]    out_r;
  logic [RESULT_BITS-1:0]    out_nxt;
  logic                      skip_r;
  logic                      skip_nxt;
  logic                      dout_r;
  logic                      conv_ready_n_r;
  logic                      conv_ready_n_nxt;
  logic                      pend_r;
  logic                      pend_nxt;
  logic [5:0]                rdc_r;
  logic [5:0]                rdc_nxt;
  logic [6:0]                fall_r;
  logic [6:0]                fall_nxt;
  logic [1:0]                addr_r;
  logic [1:0]                addr_nxt;
  logic [REG_BITS-1:0]       cfg_r [REG_COUNT];
  logic [REG_BITS-1:0]       cfg_nxt [REG_COUNT];
  logic [RESULT_BITS-1:0]    latest_r;
  logic [RESULT_BITS-1:0]    latest_nxt;
  logic [31:0]               phase_r;
  logic [31:0]               phase_nxt;
  logic [31:0]               settle_r;
  logic [31:0]               settle_nxt;
  logic [1:0]                rstlo_r;
  logic [1:0]                rstlo_nxt;
  logic                      take_r;
  logic                      take_nxt;
  logic                      restart_r;
  logic                      restart_nxt;
  logic [7:0]                cmd;
  logic                      pin_rst;
  logic                      resync;

  always_comb begin
    st_nxt      = st_r;
    in_nxt      = in_r;
    bit_nxt     = bit_r;
    len_nxt     = len_r;
    out_nxt     = out_r;
    skip_nxt    = skip_r;
    conv_ready_n_nxt    = conv_ready_n_r;
    pend_nxt    = pend_r;
    rdc_nxt     = rdc_r;
    fall_nxt    = fall_r;
    addr_nxt    = addr_r;
    cfg_nxt     = cfg_r;
    latest_nxt  = latest_r;
    take_nxt    = 1'b0;
    restart_nxt = 1'b0;
    cmd         = {in_r[6:0], din_s};
    phase_nxt   = (phase_r == PERIOD_LAST) ? 32'h0000_0000
                                           : phase_r + 32'h0000_0001;
    settle_nxt  = (settle_r != 32'h0000_0000) ? settle_r - 32'h0000_0001
                                              : settle_r;
    // Low reset pin must be seen on two master edges in a row
    rstlo_nxt   = rstn_lo ? ((rstlo_r == 2'(PIN_HOLD_MCLK)) ? rstlo_r
                                                  : rstlo_r + 2'h1) : 2'h0;
    pin_rst     = rstn_lo && (rstlo_r >= 2'(PIN_HOLD_MCLK - 1));
    resync      = sync_rise && !(cfg_r[0][CFG_CSYNC_BIT] &&
                                 phase_r == 32'h0000_0000);

    if (sclk_fall && !skip_r) begin
      out_nxt = {out_r[RESULT_BITS-2:0], 1'b0};
    end

    if (sclk_rise) begin
      skip_nxt = 1'b0;
      in_nxt   = cmd;
      bit_nxt  = bit_r + 6'h01;
      case (st_r)
        D_CMD: begin
          if (!conv_ready_n_r) begin
            rdc_nxt = rdc_r + 6'h01;
            if (rdc_r == 6'(RESULT_BITS - 1)) begin
              conv_ready_n_nxt = 1'b1;
            end
          end
          if (bit_r == 6'(REG_BITS - 1)) begin
            bit_nxt = 6'h00;
            if (cmd == CMD_RDATA) begin
              out_nxt  = latest_r;
              skip_nxt = 1'b1;
              len_nxt  = 6'(RESULT_BITS);
              conv_ready_n_nxt = 1'b1;
              st_nxt   = D_RDOUT;
            end else if (cmd[7:5] == CMD_OP_RREG) begin
              out_nxt  = {cfg_r[cmd[1:0]], {(RESULT_BITS-REG_BITS){1'b0}}};
              skip_nxt = 1'b1;
              len_nxt  = 6'(REG_BITS);
              st_nxt   = D_RDOUT;
            end else if (cmd[7:5] == CMD_OP_WREG) begin
              addr_nxt = cmd[1:0];
              st_nxt   = D_WDATA;
            end
          end
        end
        D_WDATA: begin
          if (bit_r == 6'(REG_BITS - 1)) begin
            cfg_nxt[addr_r] = cmd;
            bit_nxt         = 6'h00;
            st_nxt          = D_CMD;
          end
        end
        default: begin
          if (bit_r == len_r - 6'h01) begin
            bit_nxt = 6'h00;
            st_nxt  = D_CMD;
          end
        end
      endcase
    end

    // Parked result waits while a register word is shifting out
    if (pend_r && st_nxt == D_CMD) begin
      out_nxt  = latest_r;
      skip_nxt = 1'b1;
      pend_nxt = 1'b0;
      conv_ready_n_nxt = 1'b0;
      rdc_nxt  = 6'h00;
    end

    // A superseding result raises ready for one clock in D_CMD, or until a data phase ends, before it drops
    if (settle_r == 32'h0000_0001 ||
        (settle_r == 32'h0000_0000 && phase_r == PERIOD_LAST)) begin
      latest_nxt = sample_in;
      take_nxt   = 1'b1;
      pend_nxt   = 1'b1;
      conv_ready_n_nxt   = 1'b1;
    end

    if (sclk_hi) begin
      fall_nxt = 7'h00;
    end else if (conv_ready_n_r && !conv_ready_n_nxt) begin
      if (fall_r == 7'(IF_RESET_FALLS - 1)) begin
        fall_nxt = 7'h00;
        bit_nxt  = 6'h00;
        st_nxt   = D_CMD;
      end else begin
        fall_nxt = fall_r + 7'h01;
      end
    end

    if (resync || pin_rst) begin
      phase_nxt   = 32'h0000_0000;
      restart_nxt = 1'b1;
      conv_ready_n_nxt    = 1'b1;
      pend_nxt    = 1'b0;
      settle_nxt  = cfg_r[0][CFG_FIR_BIT] ? SYNC_WAIT : SINC_WAIT;
    end
    if (pin_rst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        cfg_nxt[i] = cfg_default(i);
      end
      settle_nxt = RESET_WAIT;
      st_nxt     = D_CMD;
      bit_nxt    = 6'h00;
      fall_nxt   = 7'h00;
    end
  end

  always_ff @(posedge link_clk) begin
    if (rst) begin
      st_r      <= D_CMD;
      in_r      <= 8'h00;
      bit_r     <= 6'h00;
      len_r     <= 6'h00;
      out_r     <= 32'h0000_0000;
      skip_r    <= 1'b0;
      dout_r    <= 1'b0;
      conv_ready_n_r    <= 1'b1;
      pend_r    <= 1'b0;
      rdc_r     <= 6'h00;
      fall_r    <= 7'h00;
      addr_r    <= 2'h0;
      for (int i = 0; i < REG_COUNT; i++) begin
        cfg_r[i] <= cfg_default(i);
      end
      latest_r  <= 32'h0000_0000;
      phase_r   <= 32'h0000_0000;
      settle_r  <= RESET_WAIT;
      rstlo_r   <= 2'h0;
      take_r    <= 1'b0;
      restart_r <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      in_r      <= in_nxt;
      bit_r     <= bit_nxt;
      len_r     <= len_nxt;
      out_r     <= out_nxt;
      skip_r    <= skip_nxt;
      dout_r    <= out_nxt[RESULT_BITS-1];
      conv_ready_n_r    <= conv_ready_n_nxt;
      pend_r    <= pend_nxt;
      rdc_r     <= rdc_nxt;
      fall_r    <= fall_nxt;
      addr_r    <= addr_nxt;
      cfg_r     <= cfg_nxt;
      latest_r  <= latest_nxt;
      phase_r   <= phase_nxt;
      settle_r  <= settle_nxt;
      rstlo_r   <= rstlo_nxt;
      take_r    <= take_nxt;
      restart_r <= restart_nxt;
    end
  end

  assign link.dout         = dout_r;
  assign link.conv_ready_n = conv_ready_n_r;
  assign sample_take       = take_r;
  assign filter_restart    = restart_r;
  assign fir_sel           = cfg_r[0][CFG_FIR_BIT];
  assign csync_en          = cfg_r[0][CFG_CSYNC_BIT];

endmodule

// ===== core/adc_host_end.sv
// Host end: drives serial clock, commands, sync and reset pulses
`timescale 1ns/10ps
module adc_host_end (
  input  wire logic                   clk,      // host clock
  input  wire logic                   rst,      // sync reset, high
  adc_link_if.host                    link,     // pins to converter
  input  wire logic                   op_valid, // operation offered
  output logic                        op_ready, // operation accepted
  input  wire adc_link_pkg::host_op_t op_code,  // operation kind
  input  wire logic [1:0]             op_addr,  // register index
  input  wire logic [7:0]             op_wdata, // register write value
  output logic                        rd_valid, // result word present
  input  wire logic                   rd_ready, // result word taken
  output logic [31:0]                 rd_data   // result word
);
  import adc_link_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_PULSE = 3'b001,
    H_WAIT  = 3'b010,
    H_CMD   = 3'b011,
    H_GAP   = 3'b100,
    H_WR    = 3'b101,
    H_RD    = 3'b110
  } host_state_t;

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [1:0] in_s1_r;
  logic [1:0] in_s2_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      in_s1_r <= 2'h2;
      in_s2_r <= 2'h2;
    end else begin
      in_s1_r <= {link.conv_ready_n, link.dout};
      in_s2_r <= in_s1_r;
    end
  end

  // ************************************************************
  // Sequencer and two-entry result buffer
  // ************************************************************
  host_state_t            st_r;
  host_state_t            st_nxt;
  host_op_t               op_r;
  host_op_t               op_nxt;
  logic [7:0]             tim_r;
  logic [7:0]             tim_nxt;
  logic [5:0]             bit_r;
  logic [5:0]             bit_nxt;
  logic [5:0]             last;
  logic [RESULT_BITS-1:0] sh_r;
  logic [RESULT_BITS-1:0] sh_nxt;
  logic [REG_BITS-1:0]    wd_r;
  logic [REG_BITS-1:0]    wd_nxt;
  logic                   sclk_r;
  logic                   sclk_nxt;
  logic                   din_r;
  logic                   din_nxt;
  logic                   sync_r;
  logic                   sync_nxt;
  logic                   rstn_r;
  logic                   rstn_nxt;
  logic                   push;
  logic [RESULT_BITS-1:0] push_data;
  logic                   hv_r;
  logic                   hv_nxt;
  logic [RESULT_BITS-1:0] hd_r;
  logic [RESULT_BITS-1:0] hd_nxt;
  logic                   sv_r;
  logic                   sv_nxt;
  logic [RESULT_BITS-1:0] sd_r;
  logic [RESULT_BITS-1:0] sd_nxt;
  logic                   opr_r;
  logic                   opr_nxt;

  always_comb begin
    st_nxt    = st_r;
    op_nxt    = op_r;
    tim_nxt   = tim_r + 8'h01;
    bit_nxt   = bit_r;
    sh_nxt    = sh_r;
    wd_nxt    = wd_r;
    sclk_nxt  = sclk_r;
    din_nxt   = din_r;
    sync_nxt  = sync_r;
    rstn_nxt  = rstn_r;
    push      = 1'b0;
    push_data = (op_r == OP_RDATA) ? sh_r
              : {{(RESULT_BITS-REG_BITS){1'b0}}, sh_r[REG_BITS-1:0]};
    last      = (st_r == H_RD && op_r == OP_RDATA) ? 6'(RESULT_BITS - 1)
                                                   : 6'(REG_BITS - 1);
    case (st_r)
      H_IDLE: begin
        tim_nxt = 8'h00;
        if (op_valid && opr_r) begin
          op_nxt  = op_code;
          wd_nxt  = op_wdata;
          bit_nxt = 6'h00;
          case (op_code)
            OP_SYNC: begin
              sync_nxt = 1'b1;
              st_nxt   = H_PULSE;
            end
            OP_RESET: begin
              rstn_nxt = 1'b0;
              st_nxt   = H_PULSE;
            end
            OP_RDATA: begin
              st_nxt = H_WAIT;
            end
            default: begin
              sh_nxt = {(op_code == OP_RREG) ? CMD_OP_RREG : CMD_OP_WREG,
                        3'h0, op_addr, {(RESULT_BITS-REG_BITS){1'b0}}};
              st_nxt = H_CMD;
            end
          endcase
        end
      end
      H_PULSE: begin
        if (tim_r == 8'(PIN_HOLD_CYC - 1)) begin
          sync_nxt = 1'b0;
          rstn_nxt = 1'b1;
        end
        // Idle level also held long enough before the next pulse
        if (tim_r == 8'(2 * PIN_HOLD_CYC - 1)) begin
          st_nxt = H_IDLE;
        end
      end
      H_WAIT: begin
        tim_nxt = 8'h00;
        if (!in_s2_r[1]) begin
          sh_nxt = {CMD_RDATA, {(RESULT_BITS-REG_BITS){1'b0}}};
          st_nxt = H_CMD;
        end
      end
      H_GAP: begin
        // Last high phase ends here, as long as the others
        sclk_nxt = 1'b0;
        din_nxt  = 1'b0;
        if (tim_r == 8'(CMD_GAP_CYC - 1)) begin
          tim_nxt = 8'h00;
          bit_nxt = 6'h00;
          sh_nxt  = {wd_r, {(RESULT_BITS-REG_BITS){1'b0}}};
          // Gap also follows every data phase before the next command
          st_nxt  = bit_r[5] ? H_IDLE
                  : (op_r == OP_WREG) ? H_WR : H_RD;
        end
      end
      default: begin
        if (tim_r == 8'h00) begin
          sclk_nxt = 1'b0;
          din_nxt  = (st_r == H_RD) ? 1'b0 : sh_r[RESULT_BITS-1];
        end
        if (tim_r == 8'(SCLK_HALF_CYC)) begin
          sclk_nxt = 1'b1;
          sh_nxt   = {sh_r[RESULT_BITS-2:0], in_s2_r[0]};
        end
        if (tim_r == 8'(2 * SCLK_HALF_CYC - 1)) begin
          tim_nxt = 8'h00;
          bit_nxt = bit_r + 6'h01;
          if (bit_r == last) begin
            // Top bit marks a finished data phase for the gap state
            bit_nxt  = (st_r == H_CMD) ? 6'h00 : 6'h3f;
            push     = (st_r == H_RD);
            st_nxt   = H_GAP;
          end
        end
      end
    endcase

    hv_nxt = hv_r;
    hd_nxt = hd_r;
    sv_nxt = sv_r;
    sd_nxt = sd_r;
    if (hv_r && rd_ready) begin
      hv_nxt = sv_r;
      hd_nxt = sd_r;
      sv_nxt = 1'b0;
    end
    if (push) begin
      if (!hv_nxt) begin
        hv_nxt = 1'b1;
        hd_nxt = push_data;
      end else begin
        sv_nxt = 1'b1;
        sd_nxt = push_data;
      end
    end
    // Full buffer stalls acceptance so a late reader loses no word
    opr_nxt = (st_nxt == H_IDLE) && !sv_nxt;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r   <= H_IDLE;
      op_r   <= OP_RDATA;
      tim_r  <= 8'h00;
      bit_r  <= 6'h00;
      sh_r   <= 32'h0000_0000;
      wd_r   <= 8'h00;
      sclk_r <= 1'b0;
      din_r  <= 1'b0;
      sync_r <= 1'b0;
      rstn_r <= 1'b1;
      hv_r   <= 1'b0;
      hd_r   <= 32'h0000_0000;
      sv_r   <= 1'b0;
      sd_r   <= 32'h0000_0000;
      opr_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      op_r   <= op_nxt;
      tim_r  <= tim_nxt;
      bit_r  <= bit_nxt;
      sh_r   <= sh_nxt;
      wd_r   <= wd_nxt;
      sclk_r <= sclk_nxt;
      din_r  <= din_nxt;
      sync_r <= sync_nxt;
      rstn_r <= rstn_nxt;
      hv_r   <= hv_nxt;
      hd_r   <= hd_nxt;
      sv_r   <= sv_nxt;
      sd_r   <= sd_nxt;
      opr_r  <= opr_nxt;
    end
  end

  assign link.sclk    = sclk_r;
  assign link.din     = din_r;
  assign link.sync    = sync_r;
  assign link.reset_n = rstn_r;
  assign op_ready     = opr_r;
  assign rd_valid     = hv_r;
  assign rd_data      = hd_r;

endmodule

// ===== core/adc_link_if.sv
// Pin bundle between converter end and host end
`timescale 1ns/10ps
interface adc_link_if;
  logic sclk;
  logic din;
  logic dout;
  logic conv_ready_n;
  logic sync;
  logic reset_n;
  modport dev (input sclk, input din, input sync, input reset_n,
               output dout, output conv_ready_n);
  modport host (output sclk, output din, output sync, output reset_n,
                input dout, input conv_ready_n);
endinterface

// ===== core/adc_link_pkg.sv
// Shared constants and types for the converter serial link
package adc_link_pkg;

  // ************************************************************
  // Clock rates and pin timing
  // ************************************************************
  localparam int CLK_NS            = 50;
  localparam int MCLK_NS           = 48;
  localparam int SCLK_PH_MAX_MCLK  = 10;
  // At least one master clock of slack below the longest phase
  localparam int SCLK_HALF_CYC     =
    (SCLK_PH_MAX_MCLK - 1) * MCLK_NS / CLK_NS;
  localparam int CMD_GAP_MCLK      = 24;
  localparam int CMD_GAP_CYC       =
    (CMD_GAP_MCLK * MCLK_NS + CLK_NS - 1) / CLK_NS;
  localparam int PIN_HOLD_MCLK     = 2;
  // Extra cycle covers phase drift between the two clocks
  localparam int PIN_HOLD_CYC      =
    (PIN_HOLD_MCLK * MCLK_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int IF_RESET_FALLS    = 64;

  // ************************************************************
  // Conversion timing
  // ************************************************************
  localparam int DATA_PERIOD_DEF   = 4096;
  localparam int FIR_SETTLE_NUM    = 16123;
  localparam int FIR_SETTLE_DEN    = 256;
  localparam int SYNC_SETTLE_MCLK  = 466;
  localparam int RESET_SETTLE_MCLK = 468;

  // ************************************************************
  // Words, commands and configuration
  // ************************************************************
  localparam int RESULT_BITS       = 32;
  localparam int REG_BITS          = 8;
  localparam int REG_COUNT         = 4;
  localparam logic [7:0] CMD_RDATA   = 8'h12;
  localparam logic [2:0] CMD_OP_RREG = 3'h1;
  localparam logic [2:0] CMD_OP_WREG = 3'h2;
  localparam logic [7:0] CFG0_RST      = 8'h01;
  localparam logic [7:0] CFG_OTHER_RST = 8'h00;
  localparam int CFG_FIR_BIT       = 0;
  localparam int CFG_CSYNC_BIT     = 1;

  typedef enum logic [2:0] {
    OP_RDATA = 3'b000,
    OP_RREG  = 3'b001,
    OP_WREG  = 3'b010,
    OP_SYNC  = 3'b011,
    OP_RESET = 3'b100
  } host_op_t;

endpackage

// ===== tb/adc_link_checker.sv
// Pin-level assertions on the converter link
`timescale 1ns/10ps
module adc_link_checker (
  input  wire logic clk,          // host clock
  input  wire logic link_clk,     // master clock
  input  wire logic rst,          // sync reset, high
  input  wire logic sclk,         // serial clock
  input  wire logic din,          // serial in
  input  wire logic dout,         // serial out
  input  wire logic conv_ready_n, // result ready, low
  input  wire logic sync,         // sync pin
  input  wire logic reset_n       // reset pin, low
);
  import adc_link_pkg::*;
  // ****************************************
  // Helper counters
  // ****************************************
  logic       sp_r, sp_nxt;
  logic [5:0] rr_r, rr_nxt;
  logic [3:0] lo_r, lo_nxt;
  // Starts saturated so the first frame after reset counts as idle
  always_comb begin
    sp_nxt = sclk;
    rr_nxt = (sclk && !sp_r) ? 6'h01 : rr_r + {5'h00, rr_r != 6'h3f};
    if (rst) rr_nxt = 6'h3f;
  end
  always_ff @(posedge clk) begin
    sp_r <= sp_nxt;
    rr_r <= rr_nxt;
  end
  always_comb lo_nxt = (sclk || rst) ? 4'h0 : lo_r + {3'h0, lo_r != 4'hf};
  always_ff @(posedge link_clk) lo_r <= lo_nxt;
  // ****************************************
  // Assertions
  // ****************************************
  sclk_high_a: assert property (@(posedge clk) disable iff (rst)
    $rose(sclk) |-> sclk[*8] ##1 !sclk) else $error("sclk high width");
  sclk_low_a: assert property (@(posedge clk) disable iff (rst)
    $fell(sclk) |-> (!sclk)[*8]) else $error("sclk low width");
  din_hold_a: assert property (@(posedge clk) disable iff (rst)
    sclk && $past(sclk) |-> $stable(din)) else $error("din moved");
  cmd_gap_a: assert property (@(posedge clk) disable iff (rst)
    $rose(sclk) |-> rr_r == 6'h10 || rr_r >= CMD_GAP_CYC)
    else $error("rise spacing");
  sync_width_a: assert property (@(posedge clk) disable iff (rst)
    $rose(sync) |-> sync[*3] ##1 (!sync)[*3]) else $error("sync width");
  reset_width_a: assert property (@(posedge clk) disable iff (rst)
    $fell(reset_n) |-> (!reset_n)[*3] ##1 reset_n)
    else $error("reset width");
  msb_hold_a: assert property (@(posedge link_clk) disable iff (rst)
    lo_r >= 4'h6 && !conv_ready_n && $past(!conv_ready_n) |-> $stable(dout))
    else $error("dout moved");
  reset_ready_a: assert property (@(posedge link_clk) disable iff (rst)
    $fell(reset_n) |-> ##[2:8] conv_ready_n) else $error("ready kept");
  cover property (@(posedge clk) disable iff (rst) $rose(sync));
  cover property (@(posedge clk) disable iff (rst) $fell(reset_n));
  cover property (@(posedge clk) disable iff (rst)
    $rose(sclk) && rr_r >= CMD_GAP_CYC);
endmodule

// ===== tb/adc_serial_sync_reset_timing_tb.sv
// Bench joining both link ends with random traffic
`timescale 1ns/10ps
module adc_serial_sync_reset_timing_tb;
  import adc_link_pkg::*;
  // ****************************************
  // Setup
  // ****************************************
  localparam int DP   = 64;
  localparam int FIRW = DP * FIR_SETTLE_NUM / FIR_SETTLE_DEN;
  logic        clk, link_clk, rst, op_valid, op_ready, rd_valid, rd_ready;
  logic        sample_take, filter_restart, fir_sel, csync_en;
  host_op_t    op_code;
  logic [1:0]  op_addr, a;
  logic [7:0]  op_wdata, d;
  logic [31:0] rd_data, sample_in, w;
  int          fails, tests_run, seed, i, k;
  int          cyc = 0;
  adc_link_if link();
  adc_dev_end #(.DATA_PERIOD(DP)) i_adc_dev_end (.link_clk(link_clk),
    .rst(rst), .link(link), .sample_in(sample_in),
    .sample_take(sample_take), .filter_restart(filter_restart),
    .fir_sel(fir_sel), .csync_en(csync_en));
  adc_host_end i_adc_host_end (.clk(clk), .rst(rst), .link(link),
    .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
    .op_addr(op_addr), .op_wdata(op_wdata), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data));
  adc_link_checker i_adc_link_checker (.clk(clk), .link_clk(link_clk),
    .rst(rst), .sclk(link.sclk), .din(link.din), .dout(link.dout),
    .conv_ready_n(link.conv_ready_n), .sync(link.sync),
    .reset_n(link.reset_n));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      fails = fails + 1;
      final_report();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [31:0] cfg_exp(input int idx);
    cfg_exp = {24'h0, idx == 0 ? CFG0_RST : CFG_OTHER_RST};
  endfunction
  task automatic do_op(input host_op_t c, input logic [1:0] ad,
                       input logic [7:0] x);
    @(negedge clk);
    op_code = c;
    op_addr = ad;
    op_wdata = x;
    op_valid = 1'b1;
    while (op_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    op_valid = 1'b0;
  endtask
  task automatic idle();
    @(negedge clk);
    while (op_ready !== 1'b1) @(negedge clk);
  endtask
  // Receiver stalls a random while before taking each word
  task automatic get_word(output logic [31:0] o);
    repeat (1 + $unsigned($random(seed)) % 4) @(negedge clk);
    while (rd_valid !== 1'b1) @(negedge clk);
    o = rd_data;
    rd_ready = 1'b1;
    @(negedge clk);
    rd_ready = 1'b0;
  endtask
  // Master clocks from restart to the first ready fall, small slack
  task automatic settle(input int e);
    int n;
    bit h;
    n = 0;
    h = 0;
    while (filter_restart !== 1'b1) @(negedge link_clk);
    while (!(h && link.conv_ready_n === 1'b0)) begin
      h = h || link.conv_ready_n === 1'b1;
      @(negedge link_clk);
      n = n + 1;
    end
    check("settle", 32'(n >= e - 8 && n <= e + 8), 32'h1);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    seed = 76;
    fails = 0;
    tests_run = 0;
    rst = 1'b1;
    op_valid = 1'b0;
    rd_ready = 1'b0;
    op_code = OP_RDATA;
    op_addr = 2'h0;
    op_wdata = 8'h00;
    sample_in = 32'h0000_0000;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    check("fir_sel", {31'h0, fir_sel}, 32'h1);
    check("csync_en", {31'h0, csync_en}, 32'h0);
    for (i = 0; i < 4; i++) begin
      do_op(OP_RREG, 2'(i), 8'h00);
      get_word(w);
      check("reg", w, cfg_exp(i));
    end
    for (i = 0; i < 6; i++) begin
      a = 2'(1 + $unsigned($random(seed)) % 3);
      d = i == 0 ? 8'hFF : 8'($random(seed));
      do_op(OP_WREG, a, d);
      do_op(OP_RREG, a, 8'h00);
      get_word(w);
      check("reg_rw", w, {24'h0, d});
    end
    do_op(OP_WREG, 2'h0, 8'h02);
    idle();
    check("csync_en", {31'h0, csync_en}, 32'h1);
    check("fir_sel", {31'h0, fir_sel}, 32'h0);
    do_op(OP_WREG, 2'h0, 8'h00);
    idle();
    fork
      do_op(OP_SYNC, 2'h0, 8'h00);
      settle(DP);
    join
    fork
      do_op(OP_RESET, 2'h0, 8'h00);
      settle(FIRW + RESET_SETTLE_MCLK);
    join
    check("fir_sel", {31'h0, fir_sel}, 32'h1);
    do_op(OP_RREG, 2'h1, 8'h00);
    get_word(w);
    check("reg1", w, cfg_exp(1));
    fork
      do_op(OP_SYNC, 2'h0, 8'h00);
      settle(FIRW + SYNC_SETTLE_MCLK);
    join
    for (i = 0; i < 4; i++) begin
      @(negedge link_clk);
      sample_in = i == 0 ? 32'h8000_0001 : 32'($random(seed));
      k = 0;
      repeat (3 * DP) begin
        @(negedge link_clk);
        k = k + int'(sample_take);
      end
      check("takes", k, 32'h3);
      do_op(OP_RDATA, 2'h0, 8'h00);
      get_word(w);
      check("rdata", w, sample_in);
    end
    d = 8'($random(seed));
    do_op(OP_WREG, 2'h2, d);
    do_op(OP_RREG, 2'h2, 8'h00);
    do_op(OP_RREG, 2'h2, 8'h00);
    // Two register reads take under 400 host clocks each
    repeat (400) @(negedge clk);
    check("op_ready_full", {31'h0, op_ready}, 32'h0);
    for (i = 0; i < 2; i++) begin
      get_word(w);
      check("buffered", w, {24'h0, d});
    end
    final_report();
  end
endmodule
